// *** design/identify_block.sv ***
// Purpose: identify parameter block, streamed as 256 words on request
// Assumes: AXI4-Lite slave for live settings; host side takes words
//   over a valid/ready stream, one word per data transfer
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module identify_block #(
  parameter logic [15:0] DEF_CYL = 16'h03E0,
  parameter logic [15:0] DEF_HEADS = 16'h0010,
  parameter logic [15:0] DEF_SPT = 16'h003F,
  parameter logic [31:0] TOTAL_SECT = 32'h000F_4200,
  parameter logic [15:0] BUF_SECTORS = 16'h0002,
  parameter logic [7:0] MAX_MULT = 8'h01,
  // arbitrary vendor word
  parameter logic [15:0] VENDOR_WORD = 16'h0000,
  // arbitrary factory identifier, right justified ascii
  parameter logic [79:0] UNIQUE_ID = 80'h2020_2020_2020_2020_3031,
  // arbitrary firmware revision ascii
  parameter logic [63:0] FW_REV = 64'h3130_2020_2020_2020,
  parameter logic [15:0] MODEL_WORD = 16'h2020
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [id_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [id_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic identify_req,
  output var id_pkg::ident_word_type id_word,
  output logic id_valid,
  input wire logic id_ready,
  output logic id_busy
);

  id_pkg::state_type state_ff;
  id_pkg::state_type nxt_state;

  // byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (be[k]) begin
        r[k*8 +: 8] = d[k*8 +: 8];
      end
    end
    return r;
  endfunction

  // address decode shared by write, read and response
  function automatic logic mapped(input logic [7:0] a);
    logic hit;
    hit = a inside {id_pkg::A_CTRL, id_pkg::A_STAT, id_pkg::A_CYL,
                    id_pkg::A_HEADS, id_pkg::A_SPT, id_pkg::A_MULT,
                    id_pkg::A_DMA, id_pkg::A_SEC_ER, id_pkg::A_ENH_ER,
                    id_pkg::A_APM, id_pkg::A_SEC_ST};
    // serial slots, word aligned
    if (a >= id_pkg::A_SN && a <= id_pkg::A_SN_END && a[1:0] == 2'h0) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // user serial slot from its byte address
  function automatic logic [2:0] sn_slot(input logic [7:0] a);
    logic [7:0] d;
    d = a - id_pkg::A_SN;
    return d[4:2];
  endfunction

  // content of one parameter word from live settings
  function automatic logic [15:0] word_of(input logic [7:0] i,
                                          input id_pkg::state_type s);
    logic [31:0] cap;
    logic [15:0] w;
    cap = 32'(s.cyl) * 32'(s.heads) * 32'(s.spt);
    w = 16'h0000;

    case (i)
      // fixed identity and default geometry
      id_pkg::WD_GEN: w = id_pkg::W_GENCONF;
      id_pkg::WD_DCYL: w = DEF_CYL;
      id_pkg::WD_DHEAD: w = DEF_HEADS;
      id_pkg::WD_DSPT: w = DEF_SPT;
      id_pkg::WD_TOT_HI: w = TOTAL_SECT[31:16];
      id_pkg::WD_TOT_LO: w = TOTAL_SECT[15:0];
      id_pkg::WD_VEND: w = VENDOR_WORD;

      // buffer and ecc description
      id_pkg::WD_BUFT: w = id_pkg::W_BUF_TYPE;
      id_pkg::WD_BUFS: w = BUF_SECTORS;
      id_pkg::WD_ECC: w = id_pkg::W_ECC_CNT;

      // capability and mode words
      id_pkg::WD_MAXM: w = {8'h00, MAX_MULT};
      id_pkg::WD_CAPS: w = id_pkg::W_CAPS;
      id_pkg::WD_PIO: w = id_pkg::W_PIO_MODE;
      id_pkg::WD_VALID: w = id_pkg::W_VALID;

      // live geometry and capacity
      id_pkg::WD_CCYL: w = s.cyl;
      id_pkg::WD_CHEAD: w = s.heads;
      id_pkg::WD_CSPT: w = s.spt;
      id_pkg::WD_CAP_LO: w = cap[15:0];
      id_pkg::WD_CAP_HI: w = cap[31:16];

      // count byte from the last multiple setting
      id_pkg::WD_MULT: w = {id_pkg::MULT_VALID, s.mult};
      id_pkg::WD_LBA_LO: w = TOTAL_SECT[15:0];
      id_pkg::WD_LBA_HI: w = TOTAL_SECT[31:16];

      // one 2-bit code selects the mode, so one bit at most
      id_pkg::WD_DMA: begin
        w = id_pkg::W_DMA_SUP;
        if (s.dma_sel != 2'h0) begin
          w[id_pkg::DMA_SEL_POS + 32'(s.dma_sel) - 1] = 1'b1;
        end
      end

      // timing and version words
      id_pkg::WD_APIO: w = id_pkg::W_ADV_PIO;
      id_pkg::WD_DMA_MIN: w = id_pkg::W_CYCLE;
      id_pkg::WD_DMA_REC: w = id_pkg::W_CYCLE;
      id_pkg::WD_PIO_MIN: w = id_pkg::W_CYCLE;
      id_pkg::WD_PIO_RDY: w = id_pkg::W_CYCLE;
      id_pkg::WD_MAJOR: w = id_pkg::W_MAJOR;
      id_pkg::WD_MINOR: w = id_pkg::W_MINOR;
      id_pkg::WD_F82: w = id_pkg::W_F82;
      id_pkg::WD_F83: w = id_pkg::W_F83;
      id_pkg::WD_F84: w = id_pkg::W_F84;

      // live security and power words
      id_pkg::WD_SEC_ER: w = s.sec_er;
      id_pkg::WD_ENH_ER: w = s.enh_er;
      id_pkg::WD_APM: w = s.apm;
      id_pkg::WD_SEC_ST: w = s.sec_st;

      // string ranges, everything else reserved
      default: begin
        if (i >= id_pkg::WD_SN_U && i <= id_pkg::WD_SN_U_END) begin
          w = s.user_sn[3'(i - id_pkg::WD_SN_U)];
        end else if (i >= id_pkg::WD_SN_F && i <= id_pkg::WD_SN_F_END) begin
          w = UNIQUE_ID[{3'(id_pkg::WD_SN_F_END - i), 4'h0} +: 16];
        end else if (i >= id_pkg::WD_FW && i <= id_pkg::WD_FW_END) begin
          w = FW_REV[{2'(id_pkg::WD_FW_END - i), 4'h0} +: 16];
        end else if (i >= id_pkg::WD_MODEL && i <= id_pkg::WD_MODEL_END) begin
          w = MODEL_WORD;
        end else begin
          w = 16'h0000;
        end
      end
    endcase
    return w;
  endfunction

  always_comb begin
    logic [31:0] wv;
    logic [31:0] rv;
    logic start;
    wv = 32'h0000_0000;
    rv = 32'h0000_0000;
    start = 1'b0;
    nxt_state = state_ff;

    // write address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_state.awgot = 1'b1;
      nxt_state.awaddr = s_axi_awaddr;
    end

    if (s_axi_wvalid && s_axi_wready) begin
      nxt_state.wgot = 1'b1;
      nxt_state.wdata = s_axi_wdata;
      nxt_state.wstrb = s_axi_wstrb;
    end

    if (state_ff.bvalid && s_axi_bready) begin
      nxt_state.bvalid = 1'b0;
    end

    // apply the held write once both halves are in
    if (state_ff.awgot && state_ff.wgot && !state_ff.bvalid) begin
      nxt_state.awgot = 1'b0;
      nxt_state.wgot = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp = mapped(state_ff.awaddr) ? id_pkg::RESP_OKAY
                                                : id_pkg::RESP_DECERR;
      case (state_ff.awaddr)
        id_pkg::A_CTRL: begin
          wv = merge(32'h0000_0000, state_ff.wdata, state_ff.wstrb);
          start = wv[id_pkg::CTRL_START_BIT];
        end

        // current geometry, multiple setting and dma select
        id_pkg::A_CYL: begin
          wv = merge({16'h0000, state_ff.cyl}, state_ff.wdata, state_ff.wstrb);
          nxt_state.cyl = wv[15:0];
        end
        id_pkg::A_HEADS: begin
          wv = merge({16'h0000, state_ff.heads}, state_ff.wdata, state_ff.wstrb);
          nxt_state.heads = wv[15:0];
        end
        id_pkg::A_SPT: begin
          wv = merge({16'h0000, state_ff.spt}, state_ff.wdata, state_ff.wstrb);
          nxt_state.spt = wv[15:0];
        end
        id_pkg::A_MULT: begin
          wv = merge({24'h00_0000, state_ff.mult}, state_ff.wdata, state_ff.wstrb);
          nxt_state.mult = wv[7:0];
        end
        id_pkg::A_DMA: begin
          wv = merge({30'h0000_0000, state_ff.dma_sel}, state_ff.wdata,
                     state_ff.wstrb);
          nxt_state.dma_sel = wv[1:0];
        end

        // live power and security settings
        id_pkg::A_SEC_ER: begin
          wv = merge({16'h0000, state_ff.sec_er}, state_ff.wdata, state_ff.wstrb);
          nxt_state.sec_er = wv[15:0];
        end
        id_pkg::A_ENH_ER: begin
          wv = merge({16'h0000, state_ff.enh_er}, state_ff.wdata, state_ff.wstrb);
          nxt_state.enh_er = wv[15:0];
        end
        id_pkg::A_APM: begin
          wv = merge({16'h0000, state_ff.apm}, state_ff.wdata, state_ff.wstrb);
          nxt_state.apm = wv[15:0];
        end
        id_pkg::A_SEC_ST: begin
          wv = merge({16'h0000, state_ff.sec_st}, state_ff.wdata, state_ff.wstrb);
          nxt_state.sec_st = wv[15:0];
        end
        default: begin
          // user serial words; other mapped writes ignored
          if (mapped(state_ff.awaddr) && state_ff.awaddr >= id_pkg::A_SN) begin
            wv = merge({16'h0000, state_ff.user_sn[sn_slot(state_ff.awaddr)]},
                       state_ff.wdata, state_ff.wstrb);
            nxt_state.user_sn[sn_slot(state_ff.awaddr)] = wv[15:0];
          end
        end
      endcase
    end

    // read channel answers one cycle after the address is taken
    if (state_ff.rvalid && s_axi_rready) begin
      nxt_state.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      // live settings; serial slots by default
      case (s_axi_araddr)
        id_pkg::A_CTRL: rv[id_pkg::CTRL_START_BIT] = id_busy;
        id_pkg::A_STAT: rv = {23'h00_0000, id_busy, state_ff.idx};
        id_pkg::A_CYL: rv = {16'h0000, state_ff.cyl};
        id_pkg::A_HEADS: rv = {16'h0000, state_ff.heads};
        id_pkg::A_SPT: rv = {16'h0000, state_ff.spt};
        id_pkg::A_MULT: rv = {24'h00_0000, state_ff.mult};
        id_pkg::A_DMA: rv = {30'h0000_0000, state_ff.dma_sel};
        id_pkg::A_SEC_ER: rv = {16'h0000, state_ff.sec_er};
        id_pkg::A_ENH_ER: rv = {16'h0000, state_ff.enh_er};
        id_pkg::A_APM: rv = {16'h0000, state_ff.apm};
        id_pkg::A_SEC_ST: rv = {16'h0000, state_ff.sec_st};
        default: begin
          if (mapped(s_axi_araddr)) begin
            rv = {16'h0000, state_ff.user_sn[sn_slot(s_axi_araddr)]};
          end
        end
      endcase

      nxt_state.rvalid = 1'b1;
      nxt_state.rdata = rv;
      nxt_state.rresp = mapped(s_axi_araddr) ? id_pkg::RESP_OKAY
                                             : id_pkg::RESP_DECERR;
    end

    // parameter word stream; a request while busy is dropped
    start = start | identify_req;
    case (state_ff.phase)
      id_pkg::PH_IDLE: begin
        if (start) begin
          nxt_state.phase = id_pkg::PH_SEND;
          nxt_state.idx = id_pkg::WD_GEN;
          nxt_state.word = word_of(id_pkg::WD_GEN, state_ff);
          nxt_state.last = 1'b0;
        end
      end

      id_pkg::PH_SEND: begin
        if (id_ready) begin
          if (state_ff.last) begin
            nxt_state.phase = id_pkg::PH_IDLE;
          end else begin
            nxt_state.idx = state_ff.idx + 8'h01;
            nxt_state.word = word_of(state_ff.idx + 8'h01, state_ff);
            nxt_state.last = (state_ff.idx + 8'h01) == id_pkg::LAST_IDX;
          end
        end
      end
      default: nxt_state.phase = id_pkg::PH_IDLE;
    endcase

    // reset last so it overrides every update above
    if (!aresetn) begin
      nxt_state = '0;
      nxt_state.phase = id_pkg::PH_IDLE;
      nxt_state.cyl = DEF_CYL;
      nxt_state.heads = DEF_HEADS;
      nxt_state.spt = DEF_SPT;
      nxt_state.mult = 8'h00;
      nxt_state.user_sn = {id_pkg::SN_USER_WORDS{id_pkg::SPACE_PAIR}};
    end
  end

  // one register holds all state
  always_ff @(posedge aclk) begin
    state_ff <= nxt_state;
  end

  // bus handshakes from held state
  assign s_axi_awready = !state_ff.awgot && !state_ff.bvalid;
  assign s_axi_wready = !state_ff.wgot && !state_ff.bvalid;
  assign s_axi_bvalid = state_ff.bvalid;
  assign s_axi_bresp = state_ff.bresp;
  assign s_axi_arready = !state_ff.rvalid;
  assign s_axi_rvalid = state_ff.rvalid;
  assign s_axi_rdata = state_ff.rdata;
  assign s_axi_rresp = state_ff.rresp;

  // stream outputs straight from the state register
  assign id_busy = state_ff.phase == id_pkg::PH_SEND;
  assign id_valid = id_busy;
  assign id_word.data = state_ff.word;
  assign id_word.index = state_ff.idx;
  assign id_word.last = state_ff.last;

endmodule // identify_block

`default_nettype wire

// *** inc/id_pkg.sv ***
// Purpose: constants and types for the identify parameter block
// Assumes: AXI4-Lite register port with 32-bit data, byte addresses
// Notes: WD_ names are word addresses inside the 256-word block
package id_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_CYL = 8'h08;
  localparam logic [7:0] A_HEADS = 8'h0C;
  localparam logic [7:0] A_SPT = 8'h10;
  localparam logic [7:0] A_MULT = 8'h14;
  localparam logic [7:0] A_DMA = 8'h18;
  localparam logic [7:0] A_SEC_ER = 8'h1C;
  localparam logic [7:0] A_ENH_ER = 8'h20;
  localparam logic [7:0] A_APM = 8'h24;
  localparam logic [7:0] A_SEC_ST = 8'h28;
  localparam logic [7:0] A_SN = 8'h30;
  localparam logic [7:0] A_SN_END = 8'h40;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam int CTRL_START_BIT = 0;
  localparam int STAT_BUSY_BIT = 8;
  localparam int DMA_SEL_POS = 8;
  localparam int SN_USER_WORDS = 5;
  localparam logic [7:0] LAST_IDX = 8'hFF;
  localparam int CYCLE_TIME_NS = 120;
  localparam logic [15:0] W_CYCLE = 16'(CYCLE_TIME_NS);
  localparam logic [15:0] W_GENCONF = 16'h044A;
  localparam logic [15:0] W_BUF_TYPE = 16'h0002;
  localparam logic [15:0] W_ECC_CNT = 16'h0004;
  localparam logic [15:0] W_CAPS = 16'h0B00;
  localparam logic [15:0] W_PIO_MODE = 16'h0200;
  localparam logic [15:0] W_VALID = 16'h0003;
  localparam logic [15:0] W_DMA_SUP = 16'h0007;
  localparam logic [15:0] W_ADV_PIO = 16'h0003;
  localparam logic [15:0] W_MAJOR = 16'h007E;
  localparam logic [15:0] W_MINOR = 16'h0019;
  localparam logic [15:0] W_F82 = 16'h706A;
  localparam logic [15:0] W_F83 = 16'h410D;
  localparam logic [15:0] W_F84 = 16'h4000;
  localparam logic [15:0] SPACE_PAIR = 16'h2020;
  localparam logic [7:0] MULT_VALID = 8'h01;
  localparam logic [7:0] WD_GEN = 8'h00;
  localparam logic [7:0] WD_DCYL = 8'h01;
  localparam logic [7:0] WD_DHEAD = 8'h03;
  localparam logic [7:0] WD_DSPT = 8'h06;
  localparam logic [7:0] WD_TOT_HI = 8'h07;
  localparam logic [7:0] WD_TOT_LO = 8'h08;
  localparam logic [7:0] WD_VEND = 8'h09;
  localparam logic [7:0] WD_SN_U = 8'h0A;
  localparam logic [7:0] WD_SN_U_END = 8'h0E;
  localparam logic [7:0] WD_SN_F = 8'h0F;
  localparam logic [7:0] WD_SN_F_END = 8'h13;
  localparam logic [7:0] WD_BUFT = 8'h14;
  localparam logic [7:0] WD_BUFS = 8'h15;
  localparam logic [7:0] WD_ECC = 8'h16;
  localparam logic [7:0] WD_FW = 8'h17;
  localparam logic [7:0] WD_FW_END = 8'h1A;
  localparam logic [7:0] WD_MODEL = 8'h1B;
  localparam logic [7:0] WD_MODEL_END = 8'h2E;
  localparam logic [7:0] WD_MAXM = 8'h2F;
  localparam logic [7:0] WD_CAPS = 8'h31;
  localparam logic [7:0] WD_PIO = 8'h33;
  localparam logic [7:0] WD_VALID = 8'h35;
  localparam logic [7:0] WD_CCYL = 8'h36;
  localparam logic [7:0] WD_CHEAD = 8'h37;
  localparam logic [7:0] WD_CSPT = 8'h38;
  localparam logic [7:0] WD_CAP_LO = 8'h39;
  localparam logic [7:0] WD_CAP_HI = 8'h3A;
  localparam logic [7:0] WD_MULT = 8'h3B;
  localparam logic [7:0] WD_LBA_LO = 8'h3C;
  localparam logic [7:0] WD_LBA_HI = 8'h3D;
  localparam logic [7:0] WD_DMA = 8'h3F;
  localparam logic [7:0] WD_APIO = 8'h40;
  localparam logic [7:0] WD_DMA_MIN = 8'h41;
  localparam logic [7:0] WD_DMA_REC = 8'h42;
  localparam logic [7:0] WD_PIO_MIN = 8'h43;
  localparam logic [7:0] WD_PIO_RDY = 8'h44;
  localparam logic [7:0] WD_MAJOR = 8'h50;
  localparam logic [7:0] WD_MINOR = 8'h51;
  localparam logic [7:0] WD_F82 = 8'h52;
  localparam logic [7:0] WD_F83 = 8'h53;
  localparam logic [7:0] WD_F84 = 8'h54;
  localparam logic [7:0] WD_SEC_ER = 8'h59;
  localparam logic [7:0] WD_ENH_ER = 8'h5A;
  localparam logic [7:0] WD_APM = 8'h5B;
  localparam logic [7:0] WD_SEC_ST = 8'h80;

  typedef enum logic {PH_IDLE = 1'b0, PH_SEND = 1'b1} phase_type;

  typedef struct packed {
    logic [15:0] data;
    logic [7:0] index;
    logic last;
  } ident_word_type;

  typedef struct packed {
    phase_type phase;
    logic [7:0] idx;
    logic [15:0] word;
    logic last;
    logic awgot;
    logic wgot;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] cyl;
    logic [15:0] heads;
    logic [15:0] spt;
    logic [7:0] mult;
    logic [1:0] dma_sel;
    logic [15:0] sec_er;
    logic [15:0] enh_er;
    logic [15:0] apm;
    logic [15:0] sec_st;
    logic [SN_USER_WORDS-1:0][15:0] user_sn;
  } state_type;
endpackage

// *** bench/identify_block_assertions.sv ***
// Purpose: stream checks on the identify block ports
// Assumes: one clock domain, synchronous active-low reset
// Notes: attached to the design by bind
`timescale 1ns/1ps
`default_nettype none
module identify_block_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic identify_req,
  input wire id_pkg::ident_word_type id_word,
  input wire logic id_valid,
  input wire logic id_ready,
  input wire logic id_busy
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_take;
    id_valid && id_ready;
  endsequence
  sequence s_adv;
    id_valid && id_word.index == $past(id_word.index) + 8'h01;
  endsequence
  property p_start;
    identify_req && !id_busy |=> id_valid && id_word.index == 8'h00 && id_word.data == 16'h044A;
  endproperty
  property p_hold;
    id_valid && !id_ready |=> id_valid && $stable(id_word);
  endproperty
  property p_step;
    s_take ##0 !id_word.last |=> s_adv;
  endproperty
  property p_end;
    s_take ##0 id_word.last |=> !id_valid;
  endproperty
  property p_last;
    id_valid |-> id_word.last == (id_word.index == 8'hFF);
  endproperty
  property p_frame;
    $rose(id_valid) |-> id_word.index == 8'h00;
  endproperty
  property p_dma_sup;
    id_valid && id_word.index == 8'h3F |-> id_word.data[2:0] == 3'h7;
  endproperty
  property p_dma_sel;
    id_valid && id_word.index == 8'h3F |-> $onehot0(id_word.data[10:8])
      && id_word.data[15:11] == 5'h00 && id_word.data[7:3] == 5'h00;
  endproperty
  property p_mult;
    id_valid && id_word.index == 8'h3B |-> id_word.data[15:8] == 8'h01;
  endproperty
  property p_cyc;
    id_valid && id_word.index inside {[8'h41:8'h44]} |-> id_word.data == 16'h0078;
  endproperty
  property p_resv;
    id_valid && id_word.index inside {[8'h45:8'h4F], [8'h5C:8'h7F], [8'h81:8'hFF]}
      |-> id_word.data == 16'h0000;
  endproperty
  a_start: assert property (p_start) else $error("word 0 missing after start");
  a_hold: assert property (p_hold) else $error("word changed while stalled");
  a_step: assert property (p_step) else $error("word index did not advance");
  a_end: assert property (p_end) else $error("stream did not stop");
  a_last: assert property (p_last) else $error("last flag wrong");
  a_frame: assert property (p_frame) else $error("block not from word 0");
  a_dma_sup: assert property (p_dma_sup) else $error("dma support bits");
  a_dma_sel: assert property (p_dma_sel) else $error("dma select bits");
  a_mult: assert property (p_mult) else $error("multiple flag byte");
  a_cyc: assert property (p_cyc) else $error("cycle time word");
  a_resv: assert property (p_resv) else $error("reserved word not zero");
endmodule // identify_block_assertions
bind identify_block identify_block_assertions chk (.aclk(aclk), .aresetn(aresetn),
  .identify_req(identify_req), .id_word(id_word), .id_valid(id_valid),
  .id_ready(id_ready), .id_busy(id_busy));
`default_nettype wire

// *** bench/host_model.sv ***
// Purpose: host side taking the word stream
// Assumes: ready may toggle every cycle in slow mode
// Notes: words stored with their index in arrival order
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire id_pkg::ident_word_type id_word,
  input wire logic id_valid,
  input wire logic slow,
  input wire logic clr,
  output logic id_ready
);
  logic [23:0] got_ff [256];
  int cnt_ff;
  always @(posedge aclk) begin
    if (!aresetn || clr) begin
      cnt_ff <= 0;
      id_ready <= 1'b0;
    end else begin
      id_ready <= slow ? ~id_ready : 1'b1;
      if (id_valid && id_ready) begin
        got_ff[cnt_ff[7:0]] <= {id_word.index, id_word.data};
        cnt_ff <= cnt_ff + 1;
      end
    end
  end
endmodule // host_model
`default_nettype wire

// *** bench/identify_block_bench.sv ***
// Purpose: self-checking bench for the identify block
// Assumes: register access over the lite bus, host model on the stream
// Notes: expected words rebuilt from shadow register values
`timescale 1ns/1ps
`default_nettype none
module identify_block_bench;
  logic aclk, aresetn, awv, wv, bre, arv, rre, req, slow, clr;
  logic awr, wrd, bv, arr, rv, vld, busy, rdy;
  logic [7:0] awa, ara, mul;
  logic [31:0] wd, rdat, d;
  logic [3:0] ws;
  logic [1:0] bresp, rresp, r, dma;
  logic [15:0] cyl, hd, spt, er, eer, apm, sst;
  logic [15:0] usn [5];
  id_pkg::ident_word_type word;
  int failures, comparisons, cyc;
  identify_block dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .identify_req(req), .id_word(word), .id_valid(vld), .id_ready(rdy), .id_busy(busy));
  host_model host (.aclk(aclk), .aresetn(aresetn), .id_word(word), .id_valid(vld),
    .slow(slow), .clr(clr), .id_ready(rdy));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] res);
    logic ta, tw, tb;
    @(posedge aclk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awv && awr;
      tw = wv && wrd;
      tb = bv;
      res = bresp;
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) bre <= 1'b0;
    end while (!tb);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] res);
    logic ta, tr;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arv && arr;
      tr = rv;
      v = rdat;
      res = rresp;
      @(posedge aclk);
      if (ta) arv <= 1'b0;
      if (tr) rre <= 1'b0;
    end while (!tr);
  endtask
  function automatic logic [15:0] exp_w(input int i);
    logic [31:0] c;
    c = 32'(cyl) * 32'(hd) * 32'(spt);
    if (i >= 10 && i <= 14) return usn[i-10];
    if ((i >= 15 && i <= 18) || (i >= 24 && i <= 46)) return 16'h2020;
    if (i >= 65 && i <= 68) return 16'h0078;
    case (i)
      0: return 16'h044A;
      1: return 16'h03E0;
      3: return 16'h0010;
      6: return 16'h003F;
      7, 61: return 16'h000F;
      8, 60: return 16'h4200;
      19: return 16'h3031;
      20, 21: return 16'h0002;
      22: return 16'h0004;
      23: return 16'h3130;
      47: return 16'h0001;
      49: return 16'h0B00;
      51: return 16'h0200;
      53, 64: return 16'h0003;
      54: return cyl;
      55: return hd;
      56: return spt;
      57: return c[15:0];
      58: return c[31:16];
      59: return {8'h01, mul};
      63: return 16'h0007 | (dma == 2'h0 ? 16'h0000 : 16'h0080 << dma);
      80: return 16'h007E;
      81: return 16'h0019;
      82: return 16'h706A;
      83: return 16'h410D;
      84: return 16'h4000;
      89: return er;
      90: return eer;
      91: return apm;
      128: return sst;
      default: return 16'h0000;
    endcase
  endfunction
  // one block, a second start while busy must be ignored
  task automatic run(input logic s, input logic via_ctrl);
    logic [31:0] g, e;
    @(posedge aclk);
    clr <= 1'b1;
    slow <= s;
    @(posedge aclk);
    clr <= 1'b0;
    if (via_ctrl) begin
      wr(id_pkg::A_CTRL, 32'h0000_0001, r);
      chk(32'(r), 32'(id_pkg::RESP_OKAY));
    end else begin
      req <= 1'b1;
      @(posedge aclk);
      req <= 1'b0;
    end
    repeat (20) @(posedge aclk);
    req <= 1'b1;
    @(posedge aclk);
    req <= 1'b0;
    rd(id_pkg::A_STAT, d, r);
    chk(32'(d[8]), 32'h1);
    while (host.cnt_ff != 256 || vld) @(posedge aclk);
    repeat (4) @(posedge aclk);
    chk(host.cnt_ff, 32'h100);
    for (int n = 0; n < 256; n++) begin
      g = 32'(host.got_ff[n]);
      e = 32'({8'(n), exp_w(n)});
      if (n inside {59, 63, 64}) chk(g, e);
      else if (n inside {[53:58], [65:68]}) chk(g, e);
      else if (n inside {[7:21], 47, 49}) chk(g, e);
      else if (n inside {0, 80, 81, 89, 90, 91, 128}) chk(g, e);
      else chk(g, e);
    end
  endtask
  initial begin
    {aresetn, awv, wv, bre, arv, rre, req, slow, clr} = 9'h000;
    {awa, ara, wd} = 48'h0;
    ws = 4'hF;
    {cyc, failures, comparisons} = 96'h0;
    {cyl, hd, spt} = 48'h03E0_0010_003F;
    {er, eer, apm, sst, mul, dma} = 74'h0;
    foreach (usn[k]) usn[k] = 16'h2020;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(id_pkg::A_MULT, d, r);
    chk(d, 32'h0);
    run(1'b0, 1'b0);
    {cyl, hd, spt, er, eer, apm, sst} = 112'h1234_0010_003F_0005_0006_0007_0009;
    mul = 8'h10;
    wr(id_pkg::A_CYL, 32'(cyl), r);
    wr(id_pkg::A_HEADS, 32'(hd), r);
    wr(id_pkg::A_SPT, 32'(spt), r);
    wr(id_pkg::A_MULT, 32'(mul), r);
    wr(id_pkg::A_SEC_ER, 32'(er), r);
    wr(id_pkg::A_ENH_ER, 32'(eer), r);
    wr(id_pkg::A_APM, 32'(apm), r);
    wr(id_pkg::A_SEC_ST, 32'(sst), r);
    for (int k = 0; k < 5; k++) begin
      usn[k] = 16'h4130 + 16'(k);
      wr(id_pkg::A_SN + 8'(4 * k), 32'(usn[k]), r);
    end
    rd(id_pkg::A_MULT, d, r);
    chk(d, 32'h10);
    chk(32'(r), 32'(id_pkg::RESP_OKAY));
    wr(8'h2C, 32'h1, r);
    chk(32'(r), 32'(id_pkg::RESP_DECERR));
    rd(8'h2C, d, r);
    chk({d[29:0], r}, {30'h0, id_pkg::RESP_DECERR});
    for (int k = 0; k < 4; k++) begin
      dma = 2'(k);
      wr(id_pkg::A_DMA, 32'(k), r);
      run(k[0], k[1]);
    end
    tally_and_finish;
  end
endmodule // identify_block_bench
`default_nettype wire
